/* core/adc_scan_defs.vh */
// constants for the converter scan control unit
//
// Functional notes
// RL1: go bit 15 starts; zero halts conversion
// RL2: scan select 00 single, 01 group, 10 continuous
// RL3: scan end interrupt only when bit 12 set
// RL4: bit 9 gates hardware trigger starts
// RL5: bit 8 picks sync or async trigger
// RL6: bit 7 enables dual trigger data duplication
// RL7: bit 6 enables group B end interrupt
// RL8: bits 4:0 pick dual trigger channel
// RL9: results are 16-bit read-only registers
// RL10: extended control sets precision and justification
// RL11: unit 0 has 8 results, unit 1 21
// RL12: converter clock per unit, max 60 MHz
// RL13: conversion time 0.48/0.45/0.42 us by precision; here all three round up to 5 mclk cycles (0.5 us)
// RL14: extended bit 15 selects left justification
// RL15: precision 00 12-bit, 01 10-bit, 10 8-bit
// RL16: default right-justified in low 12 bits
// RL17: single scan clears go bit at end
// RL18: reserved control bits read zero, ignore writes
`ifndef ADC_SCAN_DEFS_VH
`define ADC_SCAN_DEFS_VH

// ************************************************
// register offsets inside one unit (addr[5:0])
// ************************************************
`define OFS_CTRL     6'h00
`define OFS_EXT      6'h01
`define OFS_MSKA_LO  6'h02
`define OFS_MSKA_HI  6'h03
`define OFS_MSKB_LO  6'h04
`define OFS_MSKB_HI  6'h05
`define OFS_CLKDIV   6'h06
`define OFS_DUP      6'h07
`define OFS_STATUS   6'h08
`define RESULT_BIT   5

// ************************************************
// control register fields
// ************************************************
`define CTRL_GO      15
`define CTRL_SCAN_HI 14
`define CTRL_SCAN_LO 13
`define CTRL_IRQ_EN  12
`define CTRL_TRG_EN  9
`define CTRL_ASYNC   8
`define CTRL_DUAL    7
`define CTRL_GB_IRQ  6
`define CTRL_DCH_HI  4
`define CTRL_WMASK   15'h73df
`define SCAN_SINGLE  2'b00
`define SCAN_GROUP   2'b01
`define SCAN_CONT    2'b10

// ************************************************
// extended control fields and reset values
// ************************************************
`define EXT_JUSTIFY  15
`define EXT_PREC_HI  2
`define EXT_PREC_LO  1
`define EXT_WMASK    16'h8006
`define EXT_RESET    16'h0000
`define CTRL_RESET   15'h0000
`define PREC_12      2'b00
`define PREC_10      2'b01
`define PREC_8       2'b10

// ************************************************
// channel counts and timing
// ************************************************
`define NCH_U0       8
`define NCH_U1       21
`define MCLK_NS      100
`define CONV_NS_12   480
`define CONV_NS_10   450
`define CONV_NS_8    420
`define CONV_CYC(ns) (((ns) + `MCLK_NS - 1) / `MCLK_NS)

`endif

/* core/conv_timer.v */
// conversion time counter for one converter unit
`timescale 1ns/1ps
`include "adc_scan_defs.vh"

module conv_timer (
   input  wire       mclk,   // system clock
   input  wire       rst,    // sync reset, active high
   input  wire       start,  // one-cycle start of a channel
   input  wire       abort,  // software halt
   input  wire [1:0] prec,   // precision select
   input  wire [1:0] div,    // converter clock divider, 2**div
   output wire       done    // one-cycle end of channel
);

   // least times round up to whole cycles
   localparam integer C12 = `CONV_CYC(`CONV_NS_12);
   localparam integer C10 = `CONV_CYC(`CONV_NS_10);
   localparam integer C8  = `CONV_CYC(`CONV_NS_8);

   reg  [7:0] base;   // cycles at fastest converter clock
   reg  [7:0] cnt;    // cycles left
   reg        run;    // conversion in flight
   wire [7:0] total;  // scaled by divider

   // ************************************************
   // per-precision base time
   // ************************************************
   always @* begin
      case (prec)
         `PREC_10: base = C10[7:0]; // RL13
         `PREC_8:  base = C8[7:0];  // RL13
         default:  base = C12[7:0]; // RL13
      endcase
   end

   // slower converter clock stretches every conversion
   assign total = base << div; // RL12

   // ************************************************
   // countdown
   // ************************************************
   always @(posedge mclk) begin
      if (rst) begin
         run <= 1'b0;
         cnt <= 8'h00;
      end else if (abort) begin
         run <= 1'b0;
      end else if (start) begin
         run <= 1'b1;
         cnt <= total - 8'h01;
      end else if (run) begin
         if (cnt == 8'h00)
            run <= 1'b0;
         else
            cnt <= cnt - 8'h01;
      end
   end

   assign done = run & (cnt == 8'h00) & ~abort;

endmodule

/* core/result_format.v */
// places a 12-bit sample into a 16-bit result word
`timescale 1ns/1ps
`include "adc_scan_defs.vh"

module result_format (
   input  wire [11:0] raw,     // sample from the analog core
   input  wire [1:0]  prec,    // precision select
   input  wire        justify, // 1 = left justified
   output reg  [15:0] value    // formatted result
);

   // ************************************************
   // precision cut and placement
   // ************************************************
   always @* begin
      case (prec)
         `PREC_10: begin
            if (justify)
               value = {raw[11:2], 6'h00}; // RL14
            else
               value = {6'h00, raw[11:2]}; // RL15
         end
         `PREC_8: begin
            if (justify)
               value = {raw[11:4], 8'h00}; // RL14
            else
               value = {8'h00, raw[11:4]}; // RL15
         end
         default: begin
            // 11 is prohibited, treated as 12-bit
            if (justify)
               value = {raw, 4'h0}; // RL14
            else
               value = {4'h0, raw}; // RL16
         end
      endcase
   end

endmodule

/* core/adc_scan_control_unit.v */
// scan control, register file and result store of a two-unit converter
//
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`include "adc_scan_defs.vh"

module adc_scan_control_unit (
   input  wire        mclk,           // system clock, 10 MHz
   input  wire        rst,            // sync reset, active high
   input  wire [7:0]  addr,           // register address
   input  wire [15:0] wdata,          // write data
   input  wire        wr,             // write strobe
   input  wire        rd,             // read strobe
   output reg  [15:0] rdata,          // read data, cycle after rd
   input  wire [1:0]  sync_trig,      // on-chip triggers, one per unit
   input  wire [1:0]  groupb_trig,    // on-chip group B triggers
   input  wire        async_trig_n,   // external trigger pin, falling
   input  wire [11:0] raw_u0,         // unit 0 sample value
   input  wire [11:0] raw_u1,         // unit 1 sample value
   output wire [1:0]  conv_active,    // unit converting
   output wire [9:0]  conv_ch,        // channel per unit, 5 bits each
   output wire [1:0]  scan_end_irq,   // scan end pulse per unit
   output wire [1:0]  groupb_end_irq  // group B end pulse per unit
);

   // ************************************************
   // decode helpers
   // ************************************************

   // register hit for one unit at one offset
   function hit;
      input [7:0] a;
      input       u;
      input [5:0] ofs;
      begin
         hit = (a[7:6] == {1'b0, u}) && (a[5:0] == ofs);
      end
   endfunction

   // first enabled channel at or above from; msb = found
   function [5:0] next_chan;
      input [20:0] mask;
      input [4:0]  from;
      integer      i;
      begin
         next_chan = 6'h00;
         for (i = 20; i >= 0; i = i - 1) begin
            if (mask[i] && (i >= from))
               next_chan = {1'b1, i[4:0]};
         end
      end
   endfunction

   // ************************************************
   // external trigger synchroniser
   // ************************************************
   reg  trg_s1;    // first stage, read only by trg_s2
   reg  trg_s2;    // second stage
   reg  trg_prev;  // for edge detect
   wire async_fall; // falling edge seen

   // pin idles high, so reset to one avoids a false edge
   always @(posedge mclk) begin
      if (rst) begin
         trg_s1   <= 1'b1;
         trg_s2   <= 1'b1;
         trg_prev <= 1'b1;
      end else begin
         trg_s1   <= async_trig_n;
         trg_s2   <= trg_s1;
         trg_prev <= trg_s2;
      end
   end

   assign async_fall = trg_prev & ~trg_s2;

   wire [15:0] unit_rd [0:1]; // read value per unit
   wire [23:0] raw_all;       // both samples side by side

   assign raw_all = {raw_u1, raw_u0};

   // ************************************************
   // one sequencer per converter unit
   // ************************************************
   genvar u;
   generate
      for (u = 0; u < 2; u = u + 1) begin : g_unit
         localparam [0:0]  UID   = u;
         // unit 0 reaches channels 0..7, unit 1 0..20
         localparam [20:0] VALID = (u == 0) ? 21'h0000ff : 21'h1fffff; // RL11

         reg         go;      // conversion go bit
         reg  [14:0] cfg;     // rest of the control register
         reg  [15:0] ext;     // extended control
         reg  [20:0] msk_a;   // group A / main channel mask
         reg  [20:0] msk_b;   // group B channel mask
         reg  [1:0]  div;     // converter clock divider
         reg  [4:0]  ch;      // channel being converted
         reg         grp_b;   // current scan is group B
         reg  [15:0] dup;     // duplicated dual trigger result
         reg  [15:0] res [0:20]; // result store
         reg         irq_a;   // scan end pulse
         reg         irq_b;   // group B end pulse
         reg  [15:0] rd_u;    // read mux output

         wire [1:0]  mode;    // scan select
         wire [20:0] eff_a;   // enabled, existing channels A
         wire [20:0] eff_b;   // enabled, existing channels B
         wire [20:0] eff;     // mask of the running scan
         wire [5:0]  first_a; // first A channel
         wire [5:0]  first_b; // first B channel
         wire [5:0]  nxt;     // next channel of this scan
         wire [5:0]  first;   // first channel of this scan
         wire        wr_ctrl; // control write
         wire        sw_go;   // software start
         wire        sw_stop; // software halt
         wire        trg_a;   // hardware start of group A
         wire        trg_b;   // hardware start of group B
         wire        st_a;    // group A scan begins
         wire        st_b;    // group B scan begins
         wire        done;    // channel finished
         wire        t_start; // timer start
         wire [15:0] fmt;     // formatted sample

         assign mode    = cfg[`CTRL_SCAN_HI:`CTRL_SCAN_LO];
         assign eff_a   = msk_a & VALID;
         assign eff_b   = msk_b & VALID;
         assign eff     = grp_b ? eff_b : eff_a;
         assign first_a = next_chan(eff_a, 5'h00);
         assign first_b = next_chan(eff_b, 5'h00);
         assign first   = next_chan(eff, 5'h00);
         assign nxt     = next_chan(eff, ch + 5'h01);

         assign wr_ctrl = wr & hit(addr, UID, `OFS_CTRL);
         assign sw_go   = wr_ctrl & wdata[`CTRL_GO] & ~go; // RL1
         assign sw_stop = wr_ctrl & ~wdata[`CTRL_GO];      // RL1

         // hardware trigger only when enabled, source by bit 8
         assign trg_a = cfg[`CTRL_TRG_EN] & ~go & // RL4
            (cfg[`CTRL_ASYNC] ? async_fall : sync_trig[u]); // RL5
         // group B only runs in group-scan mode
         assign trg_b = cfg[`CTRL_TRG_EN] & ~go & (mode == `SCAN_GROUP) &
            groupb_trig[u]; // RL2

         // a start with no channel enabled is dropped
         assign st_a = (sw_go | trg_a) & first_a[5];
         assign st_b = trg_b & ~trg_a & ~sw_go & first_b[5];

         // chain to next channel, or loop in continuous mode
         assign t_start = st_a | st_b | (done & ~sw_stop & (nxt[5] |
            ((mode == `SCAN_CONT) & ~grp_b))); // RL2

         // ************************************************
         // control and configuration writes
         // ************************************************
         always @(posedge mclk) begin
            if (rst) begin
               cfg   <= `CTRL_RESET;
               ext   <= `EXT_RESET; // RL16
               msk_a <= 21'h000000;
               msk_b <= 21'h000000;
               div   <= 2'b00;
            end else if (wr) begin
               // reserved bits never stored
               if (hit(addr, UID, `OFS_CTRL))
                  cfg <= wdata[14:0] & `CTRL_WMASK; // RL18
               if (hit(addr, UID, `OFS_EXT))
                  ext <= wdata & `EXT_WMASK; // RL10
               if (hit(addr, UID, `OFS_MSKA_LO))
                  msk_a[15:0] <= wdata;
               if (hit(addr, UID, `OFS_MSKA_HI))
                  msk_a[20:16] <= wdata[4:0];
               if (hit(addr, UID, `OFS_MSKB_LO))
                  msk_b[15:0] <= wdata;
               if (hit(addr, UID, `OFS_MSKB_HI))
                  msk_b[20:16] <= wdata[4:0];
               // each unit keeps its own converter clock
               if (hit(addr, UID, `OFS_CLKDIV))
                  div <= wdata[1:0]; // RL12
            end
         end

         // ************************************************
         // scan sequencer
         // ************************************************
         always @(posedge mclk) begin
            if (rst) begin
               go    <= 1'b0;
               ch    <= 5'h00;
               grp_b <= 1'b0;
               irq_a <= 1'b0;
               irq_b <= 1'b0;
            end else begin
               irq_a <= 1'b0;
               irq_b <= 1'b0;
               if (sw_stop) begin
                  // halt wins over a finishing channel
                  go <= 1'b0; // RL1
               end else if (st_a) begin
                  go    <= 1'b1; // RL1
                  grp_b <= 1'b0;
                  ch    <= first_a[4:0];
               end else if (st_b) begin
                  go    <= 1'b1;
                  grp_b <= 1'b1;
                  ch    <= first_b[4:0];
               end else if (done) begin
                  if (nxt[5]) begin
                     ch <= nxt[4:0];
                  end else begin
                     // end of scan
                     irq_a <= cfg[`CTRL_IRQ_EN] & ~grp_b; // RL3
                     irq_b <= cfg[`CTRL_GB_IRQ] & grp_b;  // RL7
                     if ((mode == `SCAN_CONT) & ~grp_b) begin
                        ch <= first[4:0]; // RL2
                     end else begin
                        // single and group scans stop by themselves
                        go <= 1'b0; // RL17
                     end
                  end
               end
            end
         end

         // ************************************************
         // result store, written when a channel ends
         // ************************************************
         always @(posedge mclk) begin
            if (done & ~sw_stop) begin
               res[ch] <= fmt; // RL9
               // duplicate only for the chosen channel, mode on
               if (cfg[`CTRL_DUAL] & (ch == cfg[`CTRL_DCH_HI:0])) // RL6
                  dup <= fmt; // RL8
            end
         end

         conv_timer u_timer (
            .mclk  (mclk),
            .rst   (rst),
            .start (t_start),
            .abort (sw_stop),
            .prec  (ext[`EXT_PREC_HI:`EXT_PREC_LO]),
            .div   (div),
            .done  (done)
         );

         result_format u_fmt (
            .raw     (raw_all[u*12 +: 12]),
            .prec    (ext[`EXT_PREC_HI:`EXT_PREC_LO]), // RL10
            .justify (ext[`EXT_JUSTIFY]),
            .value   (fmt)
         );

         // ************************************************
         // read mux for this unit
         // ************************************************
         // results not yet written read as unknown in sim only;
         // software reads a channel after its scan ends
         always @* begin
            rd_u = 16'h0000;
            if (addr[`RESULT_BIT]) begin
               // results are read-only and bounded by unit size
               if (VALID[addr[4:0]])
                  rd_u = res[addr[4:0]]; // RL11
            end else begin
               case (addr[5:0])
                  `OFS_CTRL:    rd_u = {go, cfg}; // RL18
                  `OFS_EXT:     rd_u = ext;
                  `OFS_MSKA_LO: rd_u = msk_a[15:0];
                  `OFS_MSKA_HI: rd_u = {11'h000, msk_a[20:16]};
                  `OFS_MSKB_LO: rd_u = msk_b[15:0];
                  `OFS_MSKB_HI: rd_u = {11'h000, msk_b[20:16]};
                  `OFS_CLKDIV:  rd_u = {14'h0000, div};
                  `OFS_DUP:     rd_u = dup;
                  `OFS_STATUS:  rd_u = {9'h000, grp_b, go, ch};
                  default:      rd_u = 16'h0000;
               endcase
            end
         end

         assign unit_rd[u]         = rd_u;
         assign conv_active[u]     = go;
         assign conv_ch[u*5 +: 5]  = ch;
         assign scan_end_irq[u]    = irq_a;
         assign groupb_end_irq[u]  = irq_b;
      end
   endgenerate

   // ************************************************
   // read data register
   // ************************************************
   // data stand for one cycle only; unmapped space reads zero
   always @(posedge mclk) begin
      if (rst)
         rdata <= 16'h0000;
      else if (rd & ~addr[7])
         rdata <= unit_rd[addr[6]];
      else
         rdata <= 16'h0000;
   end

endmodule

/* dv/adc_scan_control_unit_props.sv */
// assertion checker watching the unit 0 side of the scan control
`timescale 1ns/1ps
module adc_scan_control_props (
   input wire        mclk,
   input wire        rst,
   input wire [7:0]  addr,
   input wire [15:0] wdata,
   input wire        wr,
   input wire        rd,
   input wire [15:0] rdata,
   input wire [1:0]  sync_trig,
   input wire [1:0]  conv_active,
   input wire [9:0]  conv_ch,
   input wire [1:0]  scan_end_irq,
   input wire [1:0]  groupb_end_irq
);
   // ****************
   // control shadow
   // ****************
   reg  [15:0] ctl0;                    // last unit 0 control write
   wire        cwr = wr && addr == 8'h00; // unit 0 control write

   // follows software writes only; the go bit here is not the live one
   always @(posedge mclk) begin
      if (rst) begin
         ctl0 <= 16'h0000;
      end else if (cwr) begin
         ctl0 <= wdata;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   // a channel is held four more cycles
   sequence s_hold;
      $stable(conv_ch[4:0]) [*4];
   endsequence
   // unless a halt cuts it short
   sequence s_stop;
      ##[0:3] !conv_active[0];
   endsequence

   a_rdata_idle: assert property (!$past(rd) |-> rdata == 16'h0000)
      else $error("read data without read");
   a_resv_zero: assert property ($past(rd) && $past(addr) == 8'h00
      |-> rdata[11:10] == 2'b00 && !rdata[5]) else $error("reserved bits set");
   a_halt_now: assert property (cwr && !wdata[15] |=> !conv_active[0])
      else $error("halt ignored");
   a_irq_enable: assert property (scan_end_irq[0] |-> ctl0[12] && $past(conv_active[0]))
      else $error("scan end pulse not enabled");
   a_irq_single: assert property (scan_end_irq[0] |=> !scan_end_irq[0])
      else $error("scan end pulse too long");
   a_gb_enable: assert property (groupb_end_irq[0] |-> ctl0[6])
      else $error("group b pulse not enabled");
   a_trig_gate: assert property (sync_trig[0] && !ctl0[9] && !conv_active[0] && !cwr
      |=> !conv_active[0]) else $error("gated trigger started");
   a_single_end: assert property (scan_end_irq[0] && ctl0[14:13] == 2'b00
      |-> !conv_active[0]) else $error("single scan kept going");
   a_cont_end: assert property (scan_end_irq[0] && ctl0[14:13] == 2'b10
      |-> conv_active[0]) else $error("continuous scan stopped");
   a_ch_dwell: assert property (conv_active[0] && $changed(conv_ch[4:0])
      |=> s_hold or s_stop) else $error("channel too short");
endmodule

bind adc_scan_control_unit adc_scan_control_props i_adc_scan_control_props (
   .mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
   .rdata(rdata), .sync_trig(sync_trig), .conv_active(conv_active),
   .conv_ch(conv_ch), .scan_end_irq(scan_end_irq), .groupb_end_irq(groupb_end_irq));

/* dv/analog_source_model.sv */
// analog channel and trigger source model for the scan control bench
`timescale 1ns/1ps
module analog_source_model (
   input  wire        mclk,
   input  wire [6:0]  salt,
   input  wire [2:0]  req,
   input  wire [1:0]  conv_active,
   input  wire [9:0]  conv_ch,
   output wire [11:0] raw_u0,
   output wire [11:0] raw_u1,
   output reg  [1:0]  sync_trig = 2'b00,
   output reg  [1:0]  groupb_trig = 2'b00,
   output reg         async_trig_n = 1'b1
);
   // ****************
   // sources
   // ****************
   reg [2:0] low_left = 3'h0;   // cycles the pin stays low

   // idle units show the inverse so a stale sample never looks right
   assign raw_u0 = conv_active[0] ? {salt, conv_ch[4:0]} : ~{salt, conv_ch[4:0]};
   assign raw_u1 = conv_active[1] ? {conv_ch[9:5], salt} : ~{conv_ch[9:5], salt};

   // one-cycle trigger pulses; pin held low a few cycles, then high
   always @(posedge mclk) begin
      sync_trig <= {1'b0, req[0]};
      groupb_trig <= {1'b0, req[1]};
      low_left <= req[2] ? 3'h4 : (low_left != 3'h0) ? low_left - 3'h1 : 3'h0;
      async_trig_n <= !(req[2] || low_left > 3'h1);
   end
endmodule

/* dv/tb_adc_scan_control_unit.sv */
// self-checking bench for the two-unit converter scan control
`timescale 1ns/1ps
module tb_adc_scan_control_unit;
   reg         mclk;           // 10 MHz clock
   reg         rst;            // sync reset
   reg  [7:0]  addr;           // register address
   reg  [15:0] wdata;          // write data
   reg         wr;             // write strobe
   reg         rd;             // read strobe
   reg  [2:0]  req;            // trigger requests to the model
   reg  [6:0]  salt;           // per-scan sample pattern
   reg  [15:0] v;              // read value
   reg  [20:0] m;              // scratch mask
   reg  [1:0]  prec;           // precision in force
   reg         just;           // justification in force
   wire [15:0] rdata;
   wire [11:0] raw_u0, raw_u1;
   wire [1:0]  sync_trig, groupb_trig, conv_active, scan_end_irq, groupb_end_irq;
   wire [9:0]  conv_ch;
   wire        async_trig_n;
   integer     bad_count = 0, n_checks = 0, cyc = 0;
   integer     seed, k, n, i, j, p, na, ni, ng;

   adc_scan_control_unit i_adc_scan_control_unit (.mclk(mclk), .rst(rst), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .sync_trig(sync_trig),
      .groupb_trig(groupb_trig), .async_trig_n(async_trig_n), .raw_u0(raw_u0),
      .raw_u1(raw_u1), .conv_active(conv_active), .conv_ch(conv_ch),
      .scan_end_irq(scan_end_irq), .groupb_end_irq(groupb_end_irq));
   analog_source_model i_analog_source_model (.mclk(mclk), .salt(salt), .req(req),
      .conv_active(conv_active), .conv_ch(conv_ch), .raw_u0(raw_u0), .raw_u1(raw_u1),
      .sync_trig(sync_trig), .groupb_trig(groupb_trig), .async_trig_n(async_trig_n));

   // ****************
   // helpers
   // ****************
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   // cuts a hang short
   always @(posedge mclk) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin
         bad_count = bad_count + 1;
         print_verdict;
      end
   end

   task print_verdict;
      begin
         $display("checks %0d mismatches %0d", n_checks, bad_count);
         if (bad_count == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
         else
            $display("CHECKS NOT OK");
         $finish;
      end
   endtask

   task check(input [127:0] nm, input [15:0] e, input [15:0] g);
      begin
         n_checks = n_checks + 1;
         if (g !== e) begin
            bad_count = bad_count + 1;
            $display("wrong value %0s expected %h seen %h", nm, e, g);
         end
      end
   endtask

   task wreg(input [7:0] a, input [15:0] d);
      begin
         @(posedge mclk);
         addr <= a;
         wdata <= d;
         wr <= 1'b1;
         @(posedge mclk);
         wr <= 1'b0;
      end
   endtask

   // data stand only in the cycle after the strobe
   task rreg(input [7:0] a, output [15:0] d);
      begin
         @(posedge mclk);
         addr <= a;
         rd <= 1'b1;
         @(posedge mclk);
         rd <= 1'b0;
         #1;
         d = rdata;
      end
   endtask

   task fire(input [2:0] b);
      begin
         @(posedge mclk);
         req <= b;
         @(posedge mclk);
         req <= 3'b000;
      end
   endtask

   // counts activity of unit 0 over a fixed span
   task watch(input integer w);
      begin
         na = 0;
         ni = 0;
         ng = 0;
         repeat (w) begin
            @(posedge mclk);
            #1;
            na = na + conv_active[0];
            ni = ni + scan_end_irq[0];
            ng = ng + groupb_end_irq[0];
         end
      end
   endtask

   // expected word: keep the top bits, then place them
   function [15:0] fmt(input [11:0] r);
      integer w;
      begin
         w = (prec == 2'b01) ? 10 : (prec == 2'b10) ? 8 : 12;
         fmt = {4'h0, r} >> (12 - w);
         if (just) begin
            fmt = fmt << (16 - w);
         end
      end
   endfunction

   // single scan by software with the end pulse on, then every result read
   task scan(input u, input [20:0] mk, input [15:0] c);
      begin
         @(posedge mclk);
         salt <= $random(seed);
         wreg({1'b0, u, 6'h02}, mk[15:0]);
         wreg({1'b0, u, 6'h03}, {11'h000, mk[20:16]});
         n = 0;
         for (j = 0; j < 21; j = j + 1) n = n + mk[j];
         wreg({1'b0, u, 6'h00}, c | 16'h9000);
         k = 0;
         while (k < 300 && scan_end_irq[u] !== 1'b1) begin
            @(posedge mclk);
            #1;
            k = k + 1;
         end
         check("scan_cycles", 16'(5 * n), k[15:0]);
         check("go_after", 16'h0000, {15'h0000, conv_active[u]});
         for (j = 0; j < 21; j = j + 1)
            if (mk[j]) begin
               rreg({1'b0, u, 1'b1, j[4:0]}, v);
               check("result", fmt(u ? {j[4:0], salt} : {salt, j[4:0]}), v);
            end
      end
   endtask

   // ****************
   // main sequence
   // ****************
   initial begin
      seed = 85948;
      {addr, wdata, wr, rd, req, salt, prec, just} = 0;
      rst = 1'b1;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      rreg(8'h00, v);
      check("ctrl_reset", 16'h0000, v);
      rreg(8'h01, v);
      check("ext_reset", 16'h0000, v);
      rreg(8'h9f, v);
      check("unmapped", 16'h0000, v);
      for (i = 0; i < 6; i = i + 1) begin
         m = (i == 0) ? 21'h007fff : $random(seed);
         wreg(8'h00, m[15:0] & 16'h7fff);
         rreg(8'h00, v);
         check("ctrl_rb", m[15:0] & 16'h73df, v);
      end
      for (p = 0; p < 3; p = p + 1)
         for (i = 0; i < 2; i = i + 1) begin
            prec = p[1:0];
            just = i[0];
            wreg(8'h01, {just, 12'h000, prec, 1'b0});
            m = $random(seed);
            scan(1'b0, (m & 21'h0000ff) | 21'h000001, 16'h0000);
         end
      wreg(8'h20, 16'hffff);
      rreg(8'h20, v);
      check("result_ro", fmt({salt, 5'h00}), v);
      scan(1'b0, 21'h00000f, 16'h0083);
      rreg(8'h07, v);
      check("duplicate", fmt({salt, 5'h03}), v);
      prec = 2'b00;
      just = 1'b1;
      wreg(8'h41, 16'h8000);
      scan(1'b1, 21'h100001, 16'h0000);
      rreg(8'h75, v);
      check("beyond_u1", 16'h0000, v);
      rreg(8'h28, v);
      check("beyond_u0", 16'h0000, v);
      for (i = 0; i < 2; i = i + 1) begin
         wreg(8'h00, 16'h8000 | (i[15:0] << 12));
         watch(22);
         check("irq_gate", i[15:0], ni[15:0]);
         wreg(8'h04, 16'h0006);
         wreg(8'h00, 16'h2200 | (i[15:0] << 6));
         fire(3'b010);
         watch(20);
         check("groupb_gate", i[15:0], ng[15:0]);
      end
      wreg(8'h00, 16'hd000);
      watch(44);
      check("cont_laps", 16'h0001, {15'h0000, ni > 1});
      wreg(8'h00, 16'h5000);
      watch(10);
      check("halt", 16'h0000, na[15:0] + ni[15:0]);
      wreg(8'h00, 16'h1000);
      fire(3'b001);
      watch(8);
      check("trig_gated", 16'h0000, na[15:0]);
      wreg(8'h00, 16'h1200);
      fire(3'b001);
      watch(24);
      check("sync_start", 16'h0001, ni[15:0]);
      wreg(8'h00, 16'h1300);
      fire(3'b001);
      watch(8);
      check("sync_ignored", 16'h0000, na[15:0]);
      fire(3'b100);
      watch(26);
      check("async_start", 16'h0001, ni[15:0]);
      print_verdict;
   end
endmodule
